/* File: seq_pkg.sv */
// Shared constants for the slot power, reset and wake sequencer and its card end
package seq_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned POWER_VALID_TO_RESET_RELEASE_TIME_MS = 100;
   localparam int unsigned CLOCK_VALID_TO_RESET_RELEASE_TIME_US = 100;
   localparam int unsigned MINIMUM_RESET_ACTIVE_TIME_US = 100;
   localparam int unsigned POWER_FAIL_TO_RESET_TIME_NS = 500;
   localparam int unsigned RESET_TO_LINK_ACTIVE_TIME_US = 20;
   localparam int unsigned IDLE_TO_RESET_TIME_NS = 100;
   localparam int unsigned CLK_PERIOD_NS = 1000000000 / CLK_HZ;
   // Least times round up, longest time rounds down, never below one cycle
   localparam int unsigned PVRR_CYC = POWER_VALID_TO_RESET_RELEASE_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned CVRR_CYC =
      (CLOCK_VALID_TO_RESET_RELEASE_TIME_US * (CLK_HZ / 1000000));
   localparam int unsigned MRA_CYC = MINIMUM_RESET_ACTIVE_TIME_US * (CLK_HZ / 1000000);
   localparam int unsigned PFR_CYC_RAW = POWER_FAIL_TO_RESET_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned PFR_CYC = (PFR_CYC_RAW < 1) ? 1 : PFR_CYC_RAW;
   localparam int unsigned LINK_WAIT_CYC = RESET_TO_LINK_ACTIVE_TIME_US * (CLK_HZ / 1000000);
   localparam int unsigned IDLE_WAIT_CYC =
      (IDLE_TO_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] LINK_PM_CTRL_RESET = 2'h0;
endpackage

/* File: slot_if.sv */
// Slot signals between the board sequencer and one add-in card
`timescale 1ns/1ps
interface slot_if;
   logic slot_fundamental_reset_n;
   logic main_power_on;
   logic slot_reference_clock_on;
   logic test_port_drive_on;
   logic link_elec_idle;
   logic card_low_power_ready;
   logic wake_n_o;
   logic wake_n_oe;
   logic wake_n_in;
   modport board (
      output slot_fundamental_reset_n,
      output main_power_on,
      output slot_reference_clock_on,
      output test_port_drive_on,
      input link_elec_idle,
      input card_low_power_ready,
      input wake_n_in
   );
   modport card (
      input slot_fundamental_reset_n,
      input main_power_on,
      input slot_reference_clock_on,
      output link_elec_idle,
      output card_low_power_ready,
      output wake_n_o,
      output wake_n_oe,
      input wake_n_in
   );
endinterface

/* File: slot_sequencer.sv */
// Board-side slot power, clock and fundamental reset sequencer with wake input
//
// Behaviour
// - Release reset 100 ms after rails good
// - Clock stable set time before reset release
// - Sleep entry: reset before power off
// - Power loss: reset within fail interval (rails are watched in RUN only; IDLE_WAIT still waits for the card)
// - Card held in reset while asserted
// - Card link power field resets to 00b
// - Card low-power ready before sleep transition
// - Power and clock stay off until wake
// - Wake restores power, repeats power-up sequence
// - Link idle before reset for sleep
// - Reset asserted before any power removal
// - Clock, test port stop after reset
// - Reset held at least minimum active time
// - Card link idle after release minimum
// - Card pulls wake low only to wake
// - Wake line treated as asynchronous
// - Shared or per-slot wake inputs accepted
// - Wake ignored during hot-plug events
// - Wake only restores power, no interrupt
// - Card never pulls wake otherwise
// - Both ends fully support wake line
`timescale 1ns/1ps
module slot_sequencer #(
   parameter int unsigned WAKE_INPUTS = 1,
   parameter int unsigned PVRR_CYCLES = seq_pkg::PVRR_CYC,
   parameter int unsigned CVRR_CYCLES = seq_pkg::CVRR_CYC,
   parameter int unsigned MRA_CYCLES = seq_pkg::MRA_CYC,
   parameter int unsigned PFR_CYCLES = seq_pkg::PFR_CYC
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic power_on_req,
   input wire logic sleep_req,
   input wire logic power_down_req,
   input wire logic rails_good,
   input wire logic ref_clock_stable,
   input wire logic hot_plug_event,
   input wire logic [WAKE_INPUTS-1:0] wake_n_extra,
   output logic slot_powered,
   output logic in_sleep,
   slot_if.board slot
);
   localparam int CW = 32;

   // Counters are 32 bits wide, so any int unsigned count fits
   if (WAKE_INPUTS < 1 || PVRR_CYCLES < 1 || CVRR_CYCLES < 1 || MRA_CYCLES < 1 ||
       PFR_CYCLES < 1 || CVRR_CYCLES > PVRR_CYCLES) begin : g_param_check
      $error("slot_sequencer: unsupported parameter values");
   end

   typedef enum logic [2:0] {OFF, RAMP, RUN, IDLE_WAIT, RST_HOLD, SLEEP, FAIL_WAIT} st_t;

   function automatic logic [CW-1:0] cnt_step(input logic [CW-1:0] c, input logic run);
      cnt_step = run ? ((c == '1) ? c : c + 32'h1) : 32'h0;
   endfunction

   st_t st_r, st_nxt;
   logic [CW-1:0] pcnt_r, pcnt_nxt;
   logic [CW-1:0] ccnt_r, ccnt_nxt;
   logic [CW-1:0] rcnt_r, rcnt_nxt;
   logic [CW-1:0] fcnt_r, fcnt_nxt;
   logic rst_n_r, rst_n_nxt;
   logic pwr_r, pwr_nxt;
   logic clk_on_r, clk_on_nxt;
   logic tp_r, tp_nxt;
   logic sleep_r, sleep_nxt;
   logic slp_pend_r, slp_pend_nxt;
   logic [WAKE_INPUTS:0] wk_meta_r, wk_sync_r;
   logic wake_evt;

   // Wake is asynchronous: first stage read only by the second
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         wk_meta_r <= '1;
         wk_sync_r <= '1;
      end else if (clk_en) begin
         wk_meta_r <= {wake_n_extra, slot.wake_n_in};
         wk_sync_r <= wk_meta_r;
      end
   end

   // Any shared or per-slot line may wake; masked during hot-plug
   assign wake_evt = !(&wk_sync_r) && !hot_plug_event;

   always_comb begin
      st_nxt = st_r;
      rst_n_nxt = rst_n_r;
      pwr_nxt = pwr_r;
      clk_on_nxt = clk_on_r;
      tp_nxt = tp_r;
      sleep_nxt = sleep_r;
      slp_pend_nxt = slp_pend_r;
      pcnt_nxt = cnt_step(pcnt_r, pwr_r && rails_good);
      ccnt_nxt = cnt_step(ccnt_r, clk_on_r && ref_clock_stable);
      rcnt_nxt = cnt_step(rcnt_r, !rst_n_r);
      fcnt_nxt = cnt_step(fcnt_r, pwr_r && !rails_good && st_r == RUN);
      case (st_r)
         OFF: begin
            if (power_on_req) begin
               pwr_nxt = 1'b1;
               clk_on_nxt = 1'b1;
               st_nxt = RAMP;
            end
         end
         RAMP: begin
            // Release only after rails, clock and minimum active time
            if (pcnt_r >= CW'(PVRR_CYCLES) && ccnt_r >= CW'(CVRR_CYCLES) &&
                rcnt_r >= CW'(MRA_CYCLES)) begin
               rst_n_nxt = 1'b1;
               tp_nxt = 1'b1;
               st_nxt = RUN;
            end
         end
         RUN: begin
            if (fcnt_r + 32'h1 >= CW'(PFR_CYCLES)) begin
               // Surprise loss: reset with no warning phase
               rst_n_nxt = 1'b0;
               st_nxt = FAIL_WAIT;
            end else if (sleep_req || power_down_req) begin
               slp_pend_nxt = sleep_req;
               st_nxt = IDLE_WAIT;
            end
         end
         IDLE_WAIT: begin
            // Wait for idle link and low-power card before reset
            if (slot.link_elec_idle && slot.card_low_power_ready) begin
               rst_n_nxt = 1'b0;
               st_nxt = RST_HOLD;
            end
         end
         RST_HOLD: begin
            // Reset already low before clock, test port and power drop
            clk_on_nxt = 1'b0;
            tp_nxt = 1'b0;
            pwr_nxt = 1'b0;
            sleep_nxt = slp_pend_r;
            st_nxt = slp_pend_r ? SLEEP : OFF;
         end
         SLEEP: begin
            // Stay off until a wake, which only restarts power
            if (wake_evt) begin
               pwr_nxt = 1'b1;
               clk_on_nxt = 1'b1;
               sleep_nxt = 1'b0;
               st_nxt = RAMP;
            end
         end
         FAIL_WAIT: begin
            clk_on_nxt = 1'b0;
            tp_nxt = 1'b0;
            pwr_nxt = 1'b0;
            st_nxt = OFF;
         end
         default: st_nxt = OFF;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         st_r <= OFF;
         pcnt_r <= '0;
         ccnt_r <= '0;
         rcnt_r <= '0;
         fcnt_r <= '0;
         rst_n_r <= 1'b0;
         pwr_r <= 1'b0;
         clk_on_r <= 1'b0;
         tp_r <= 1'b0;
         sleep_r <= 1'b0;
         slp_pend_r <= 1'b0;
      end else if (clk_en) begin
         st_r <= st_nxt;
         pcnt_r <= pcnt_nxt;
         ccnt_r <= ccnt_nxt;
         rcnt_r <= rcnt_nxt;
         fcnt_r <= fcnt_nxt;
         rst_n_r <= rst_n_nxt;
         pwr_r <= pwr_nxt;
         clk_on_r <= clk_on_nxt;
         tp_r <= tp_nxt;
         sleep_r <= sleep_nxt;
         slp_pend_r <= slp_pend_nxt;
      end
   end

   assign slot.slot_fundamental_reset_n = rst_n_r;
   assign slot.main_power_on = pwr_r;
   assign slot.slot_reference_clock_on = clk_on_r;
   assign slot.test_port_drive_on = tp_r;
   assign slot_powered = pwr_r;
   assign in_sleep = sleep_r;
endmodule

/* File: slot_card.sv */
// Card-side logic: reset honouring, link idle control and wake line drive
`timescale 1ns/1ps
module slot_card #(
   parameter int unsigned LINK_WAIT_CYCLES = seq_pkg::LINK_WAIT_CYC
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic wake_request,
   input wire logic go_low_power,
   input wire logic link_train_req,
   input wire logic pm_ctrl_we,
   input wire logic [1:0] pm_ctrl_wdata,
   output logic func_in_reset,
   output logic link_active,
   output logic [1:0] link_pm_ctrl,
   slot_if.card slot
);
   if (LINK_WAIT_CYCLES < 1) begin : g_param_check
      $error("slot_card: LINK_WAIT_CYCLES must be at least 1");
   end

   logic [31:0] wcnt_r, wcnt_nxt;
   logic act_r, act_nxt;
   logic lp_r, lp_nxt;
   logic frst_r, frst_nxt;
   logic wk_r, wk_nxt;
   logic [1:0] pmc_r, pmc_nxt;
   logic card_off;

   assign card_off = !slot.slot_fundamental_reset_n || !slot.main_power_on;

   always_comb begin
      frst_nxt = card_off;
      wcnt_nxt = card_off ? 32'h0 : ((wcnt_r == '1) ? wcnt_r : wcnt_r + 32'h1);
      // Link leaves idle only after the post-release wait
      act_nxt = !card_off && (act_r || (link_train_req && wcnt_r >= 32'(LINK_WAIT_CYCLES)));
      lp_nxt = !card_off && (lp_r || go_low_power);
      if (lp_nxt)
         act_nxt = 1'b0;
      // Field returns to 00b on every power-up or resume
      pmc_nxt = card_off ? seq_pkg::LINK_PM_CTRL_RESET : (pm_ctrl_we ? pm_ctrl_wdata : pmc_r);
      // Drive wake only on a real request, even when unpowered
      wk_nxt = wake_request;
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         wcnt_r <= '0;
         act_r <= 1'b0;
         lp_r <= 1'b0;
         frst_r <= 1'b1;
         wk_r <= 1'b0;
         pmc_r <= 2'h0;
      end else if (clk_en) begin
         wcnt_r <= wcnt_nxt;
         act_r <= act_nxt;
         lp_r <= lp_nxt;
         frst_r <= frst_nxt;
         wk_r <= wk_nxt;
         pmc_r <= pmc_nxt;
      end
   end

   assign slot.link_elec_idle = !act_r;
   assign slot.card_low_power_ready = lp_r;
   assign slot.wake_n_o = 1'b0;
   assign slot.wake_n_oe = wk_r;
   assign func_in_reset = frst_r;
   assign link_active = act_r;
   assign link_pm_ctrl = pmc_r;
endmodule

/* File: slot_seq_asserts.sv */
// Interface checks between the slot sequencer and the card
`timescale 1ns/1ps
module slot_seq_asserts #(
   parameter int unsigned PVRR_CYCLES = 50,
   parameter int unsigned CVRR_CYCLES = 10,
   parameter int unsigned MRA_CYCLES = 10,
   parameter int unsigned LINK_WAIT_CYCLES = 5
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic slot_fundamental_reset_n,
   input wire logic main_power_on,
   input wire logic slot_reference_clock_on,
   input wire logic test_port_drive_on,
   input wire logic link_elec_idle,
   input wire logic card_low_power_ready
);
   logic [15:0] dwell_r;
   logic [15:0] dwell_nxt;
   logic last_r;
   // Cycles the slot reset has held its level; saturates so long runs never wrap
   always_comb begin
      dwell_nxt = (slot_fundamental_reset_n != last_r) ? 16'h0 :
         dwell_r + {15'h0, dwell_r != 16'hFFFF};
   end
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         dwell_r <= 16'h0;
         last_r <= 1'b0;
      end else begin
         dwell_r <= dwell_nxt;
         last_r <= slot_fundamental_reset_n;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   property p_rst_before_off;
      $fell(main_power_on) |-> !slot_fundamental_reset_n && !$past(slot_fundamental_reset_n);
   endproperty
   a_rst_before_off: assert property (p_rst_before_off)
      else $error("power removed before slot reset");
   property p_clk_after_rst;
      $fell(slot_reference_clock_on) |-> !$past(slot_fundamental_reset_n);
   endproperty
   a_clk_after_rst: assert property (p_clk_after_rst)
      else $error("clock stopped before slot reset");
   property p_test_after_rst;
      $fell(test_port_drive_on) |-> !$past(slot_fundamental_reset_n);
   endproperty
   a_test_after_rst: assert property (p_test_after_rst)
      else $error("test port stopped before slot reset");
   property p_rel_power;
      $rose(slot_fundamental_reset_n) |-> main_power_on && $past(main_power_on, PVRR_CYCLES);
   endproperty
   a_rel_power: assert property (p_rel_power)
      else $error("reset released too soon after power");
   property p_rel_clock;
      $rose(slot_fundamental_reset_n) |-> $past(slot_reference_clock_on, CVRR_CYCLES);
   endproperty
   a_rel_clock: assert property (p_rel_clock)
      else $error("reset released too soon after clock");
   property p_min_active;
      $rose(slot_fundamental_reset_n) |-> dwell_r >= 16'(MRA_CYCLES - 1);
   endproperty
   a_min_active: assert property (p_min_active)
      else $error("slot reset pulse too short");
   property p_idle_before_rst;
      // Managed transitions only; a surprise loss may cut an active link
      $fell(slot_fundamental_reset_n) && $past(card_low_power_ready) |-> $past(link_elec_idle);
   endproperty
   a_idle_before_rst: assert property (p_idle_before_rst)
      else $error("link active when slot reset asserted");
   property p_idle_in_rst;
      // The card registers the reset, so its link drops one cycle later
      !slot_fundamental_reset_n && !$past(slot_fundamental_reset_n) |-> link_elec_idle;
   endproperty
   a_idle_in_rst: assert property (p_idle_in_rst)
      else $error("card link active during slot reset");
   property p_link_wait;
      $fell(link_elec_idle) |-> slot_fundamental_reset_n && dwell_r >= 16'(LINK_WAIT_CYCLES - 1);
   endproperty
   a_link_wait: assert property (p_link_wait)
      else $error("link left idle too soon after release");
   property p_pwr_clk;
      main_power_on == slot_reference_clock_on;
   endproperty
   a_pwr_clk: assert property (p_pwr_clk)
      else $error("power and clock disagree");
endmodule

/* File: slot_power_reset_wake_sequencer_test.sv */
// Testbench joining the slot sequencer and card through the slot interface
`timescale 1ns/1ps
module slot_power_reset_wake_sequencer_test;
   localparam int PV = 50;
   localparam int LW = 5;
   localparam int CV = 10;
   localparam int MR = 10;
   localparam int PF = 10;
   logic core_clk = 0, reset_n = 0, pon = 0, slp = 0, pdn = 0, rails = 1, hot = 0, wx = 1;
   logic wreq = 0, lowp = 0, train = 0, we = 0, powered, in_sleep, frst, lact;
   logic ce = 1, stable = 1;
   logic [1:0] wd = 2'h0;
   logic [1:0] pm;
   int bad_count = 0, cmp_count = 0, n;
   slot_if s();
   // Open-drain wake line: low while the card enables its drive, else pulled up
   assign s.wake_n_in = s.wake_n_oe ? s.wake_n_o : 1'b1;
   slot_sequencer #(.PVRR_CYCLES(PV), .CVRR_CYCLES(CV), .MRA_CYCLES(MR), .PFR_CYCLES(PF))
   slot_sequencer_i (.core_clk(core_clk), .reset_n(reset_n), .clk_en(ce),
      .power_on_req(pon), .sleep_req(slp), .power_down_req(pdn), .rails_good(rails),
      .ref_clock_stable(stable), .hot_plug_event(hot), .wake_n_extra(wx),
      .slot_powered(powered), .in_sleep(in_sleep), .slot(s.board));
   slot_card #(.LINK_WAIT_CYCLES(LW)) slot_card_i (.core_clk(core_clk), .reset_n(reset_n),
      .clk_en(ce), .wake_request(wreq), .go_low_power(lowp), .link_train_req(train),
      .pm_ctrl_we(we), .pm_ctrl_wdata(wd), .func_in_reset(frst), .link_active(lact),
      .link_pm_ctrl(pm), .slot(s.card));
   slot_seq_asserts #(.PVRR_CYCLES(PV), .CVRR_CYCLES(CV), .MRA_CYCLES(MR),
      .LINK_WAIT_CYCLES(LW)) slot_seq_asserts_i (.core_clk(core_clk), .reset_n(reset_n),
      .slot_fundamental_reset_n(s.slot_fundamental_reset_n), .main_power_on(s.main_power_on),
      .slot_reference_clock_on(s.slot_reference_clock_on),
      .test_port_drive_on(s.test_port_drive_on), .link_elec_idle(s.link_elec_idle),
      .card_low_power_ready(s.card_low_power_ready));
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   task chk(input string nm, input logic [2:0] e, input logic [2:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task cyc(input int k);
      repeat (k) @(negedge core_clk);
   endtask
   // Bounded wait; n returns the cycles spent
   task automatic wait_on(ref logic sg, input logic v);
      n = 0;
      while (sg !== v && n < 300) begin
         cyc(1);
         n++;
      end
   endtask
   // A late clock holds the release until the clock-valid time has passed
   task t_up(input logic late_clk);
      stable = !late_clk;
      pon = 1;
      cyc(1);
      pon = 0;
      cyc(1);
      chk("power_clock", 3'h3, {s.main_power_on, s.slot_reference_clock_on});
      chk("card_in_reset", 3'h1, frst);
      if (late_clk) begin
         cyc(PV + 10);
         chk("clock_gate", 3'h0, s.slot_fundamental_reset_n);
         stable = 1;
         wait_on(s.slot_fundamental_reset_n, 1'b1);
         chk("clock_release", 3'h1, n >= CV - 2 && n < CV + 6);
      end else begin
         wait_on(s.slot_fundamental_reset_n, 1'b1);
         chk("release_time", 3'h1, n >= PV - 2 && n < PV + 6);
      end
      chk("pm_field_init", 3'h0, pm);
      train = 1;
      wait_on(lact, 1'b1);
      chk("link_wait", 3'h1, n >= LW - 1 && n < 300);
   endtask
   task t_sleep(input logic extra);
      we = 1;
      wd = 2'h3;
      cyc(1);
      we = 0;
      chk("pm_write", 3'h3, pm);
      lowp = 1;
      train = 0;
      slp = 1;
      wait_on(s.slot_fundamental_reset_n, 1'b0);
      slp = 0;
      lowp = 0;
      chk("idle_first", 3'h1, s.link_elec_idle);
      cyc(2);
      chk("sleep_off", 3'h1, {powered, s.slot_reference_clock_on, in_sleep});
      hot = 1;
      wreq = !extra;
      wx = !extra;
      cyc(20);
      chk("hot_plug_mask", 3'h0, s.main_power_on);
      hot = 0;
      wait_on(s.main_power_on, 1'b1);
      chk("wake_time", 3'h1, n < 8);
      wreq = 0;
      wx = 1;
      wait_on(s.slot_fundamental_reset_n, 1'b1);
      chk("pm_field_resume", 3'h0, pm);
   endtask
   // Surprise loss with the link up, as it would be in service
   task t_fail;
      train = 1;
      wait_on(lact, 1'b1);
      chk("fail_link_up", 3'h1, lact);
      rails = 0;
      wait_on(s.slot_fundamental_reset_n, 1'b0);
      chk("fail_time", 3'h1, n <= PF + 2);
      cyc(2);
      chk("fail_off", 3'h0, {powered, s.slot_reference_clock_on, s.test_port_drive_on});
      chk("fail_card", 3'h1, {lact, frst});
      rails = 1;
   endtask
   // With the enable low, a rail drop must not be acted on
   task t_hold;
      ce = 0;
      rails = 0;
      cyc(PF + 10);
      chk("freeze_hold", 3'h7, {s.slot_fundamental_reset_n, powered, lact});
      rails = 1;
      ce = 1;
      cyc(2);
      chk("freeze_resume", 3'h7, {s.slot_fundamental_reset_n, powered, lact});
   endtask
   task t_down;
      train = 0;
      lowp = 1;
      pdn = 1;
      wait_on(s.slot_fundamental_reset_n, 1'b0);
      pdn = 0;
      lowp = 0;
      cyc(2);
      chk("down_off", 3'h0, {powered, in_sleep, s.test_port_drive_on});
   endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      // Whole sequence needs well under 1000 cycles; this bound is generous
      #1000000;
      bad_count++;
      wrap_up();
   end
   initial begin
      cyc(20);
      reset_n = 1;
      t_up(1'b0);
      t_sleep(1'b0);
      t_sleep(1'b1);
      t_fail();
      t_up(1'b1);
      t_hold();
      t_down();
      wrap_up();
   end
endmodule
